// file: design/tse_pkg.sv
// Shared types and constants for the trap, system-call and breakpoint unit.
package tse_pkg;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int XLEN = 64;
    localparam int HALF = 32;
    localparam int IMM_W = 16;
    localparam int INFL_W = 4;
    localparam logic [INFL_W-1:0] INFL_RST = 4'h0;
    localparam logic [INFL_W-1:0] INFL_ONE = 4'h1;
    localparam logic [INFL_W-1:0] INFL_MAX = 4'hf;
    localparam logic [XLEN-1:0] EPC_RST = 64'h0000_0000_0000_0000;

    // ************************************************************
    // Operation classes handed over by the instruction decoder
    // ************************************************************
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_LOAD = 5'h01,
        OP_STORE = 5'h02,
        OP_SYNC = 5'h03,
        OP_SYSCALL = 5'h04,
        OP_BREAK = 5'h05,
        OP_TRAP_GE_REG_SIGNED = 5'h06,
        OP_TRAP_GE_REG_UNSIGNED = 5'h07,
        OP_TRAP_LT_REG_SIGNED = 5'h08,
        OP_TRAP_LT_REG_UNSIGNED = 5'h09,
        OP_TRAP_EQ_REG = 5'h0a,
        OP_TRAP_NE_REG = 5'h0b,
        OP_TRAP_GE_IMM_SIGNED = 5'h0c,
        OP_TRAP_GE_IMM_UNSIGNED = 5'h0d,
        OP_TRAP_LT_IMM_SIGNED = 5'h0e,
        OP_TRAP_LT_IMM_UNSIGNED = 5'h0f,
        OP_TRAP_EQ_IMM = 5'h10,
        OP_TRAP_NE_IMM = 5'h11,
        OP_OTHER = 5'h12
    } tse_op_t;

    typedef enum logic [1:0] {
        CMP_GE = 2'h0,
        CMP_LT = 2'h1,
        CMP_EQ = 2'h2,
        CMP_NE = 2'h3
    } tse_cmp_t;

    typedef enum logic [1:0] {
        CAUSE_NONE = 2'h0,
        CAUSE_TRAP = 2'h1,
        CAUSE_SYSCALL = 2'h2,
        CAUSE_BREAK = 2'h3
    } tse_cause_t;

    typedef enum logic [0:0] {
        ST_RUN = 1'h0,
        ST_RAISE = 1'h1
    } tse_state_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic mode32;
        tse_op_t op;
        logic [XLEN-1:0] pc;
        logic [XLEN-1:0] first_source_register;
        logic [XLEN-1:0] second_source_register;
        logic [IMM_W-1:0] imm;
    } tse_ex_req_t;

    typedef struct packed {
        logic valid;
        tse_cause_t cause;
        logic [XLEN-1:0] epc;
    } tse_exc_t;

    localparam tse_exc_t EXC_RST = '{valid: 1'b0, cause: CAUSE_NONE, epc: EPC_RST};

endpackage

// file: design/tse_trap_cmp.sv
// Operand comparator that evaluates one trap condition.
`timescale 1ns/1ns
module tse_trap_cmp
    import tse_pkg::*;
(
    input wire logic [XLEN-1:0] lhs,
    input wire logic [XLEN-1:0] rhs,
    input wire logic is_signed,
    input wire tse_cmp_t cond,
    output logic hit
);

    logic less;

    always_comb begin
        if (is_signed) begin
            less = $signed(lhs) < $signed(rhs); // RULE4
        end else begin
            less = lhs < rhs; // RULE5
        end
    end

    always_comb begin
        case (cond)
            CMP_GE: hit = !less; // RULE6 RULE12
            CMP_LT: hit = less; // RULE7 RULE13
            CMP_EQ: hit = lhs == rhs; // RULE8 RULE14
            CMP_NE: hit = lhs != rhs; // RULE9 RULE15
            default: hit = 1'b0;
        endcase
    end

endmodule

// file: design/tse_sync_gate.sv
// Tracks loads and stores in flight and holds later ones behind a synchronise.
`timescale 1ns/1ns
module tse_sync_gate
    import tse_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic mem_issue,
    input wire logic mem_done,
    input wire logic sync_issue,
    output logic mem_wait,
    output logic [INFL_W-1:0] inflight
);

    logic [INFL_W-1:0] count_ff;
    logic [INFL_W-1:0] nxt_count;
    logic pending_ff;
    logic inc;
    logic dec;

    // A completion with nothing outstanding is ignored so the count cannot wrap.
    assign dec = mem_done && (count_ff != INFL_RST);
    assign inc = mem_issue && (count_ff != INFL_MAX);

    always_comb begin
        nxt_count = count_ff;
        if (inc && !dec) begin
            nxt_count = count_ff + INFL_ONE;
        end else if (dec && !inc) begin
            nxt_count = count_ff - INFL_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= INFL_RST;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // A new synchronise only sets pending_ff when accesses remain after this cycle's completion.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_ff <= 1'b0;
        end else if (sync_issue) begin
            pending_ff <= nxt_count != INFL_RST; // RULE1
        end else if (nxt_count == INFL_RST) begin
            pending_ff <= 1'b0;
        end
    end

    assign mem_wait = pending_ff; // RULE1
    assign inflight = count_ff;

endmodule

// file: design/tse_exc_unit.sv
// Special-instruction unit: synchronise, system call, breakpoint and traps.
//
// Operation
// (RULE1) Synchronise holds later loads and stores until drained.
// (RULE2) System call always raises its exception.
// (RULE3) Breakpoint always raises its exception.
// (RULE4) Signed traps compare as two's complement.
// (RULE5) Unsigned traps compare as unsigned magnitudes.
// (RULE6) Register greater-or-equal traps when first not below.
// (RULE7) Register less-than traps when first strictly below.
// (RULE8) Register equality traps on identical values.
// (RULE9) Register inequality traps on differing values.
// (RULE10) Signed immediate sign-extended to full width.
// (RULE11) Unsigned immediate extension selectable, zero by default.
// (RULE12) Immediate greater-or-equal traps when not below.
// (RULE13) Immediate less-than traps when strictly below.
// (RULE14) Immediate equality traps on equal values.
// (RULE15) Immediate inequality traps on differing values.
// (RULE16) False trap completes with no side effect.
// (RULE17) Exceptions are precise, cancelling excepting and later.
`timescale 1ns/1ns
module tse_exc_unit
    import tse_pkg::*;
#(
    parameter bit UIMM_SIGN_EXT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire tse_ex_req_t ex_req,
    input wire logic mem_done,
    input wire logic exc_ack,
    output logic ex_stall,
    output logic ex_done,
    output logic ex_flush,
    output tse_exc_t exc_out,
    output logic [INFL_W-1:0] mem_inflight
);

    // ************************************************************
    // Decode of the operation class
    // ************************************************************
    logic is_mem;
    logic is_sync;
    logic is_syscall;
    logic is_break;
    logic is_trap;
    logic use_imm;
    logic cmp_signed;
    tse_cmp_t cmp_cond;

    always_comb begin
        is_mem = 1'b0;
        is_sync = 1'b0;
        is_syscall = 1'b0;
        is_break = 1'b0;
        is_trap = 1'b0;
        use_imm = 1'b0;
        cmp_signed = 1'b0;
        cmp_cond = CMP_EQ;
        case (ex_req.op)
            OP_LOAD, OP_STORE: begin
                is_mem = 1'b1;
            end
            OP_SYNC: begin
                is_sync = 1'b1;
            end
            OP_SYSCALL: begin
                is_syscall = 1'b1;
            end
            OP_BREAK: begin
                is_break = 1'b1;
            end
            OP_TRAP_GE_REG_SIGNED: begin
                is_trap = 1'b1;
                cmp_signed = 1'b1;
                cmp_cond = CMP_GE;
            end
            OP_TRAP_GE_REG_UNSIGNED: begin
                is_trap = 1'b1;
                cmp_cond = CMP_GE;
            end
            OP_TRAP_LT_REG_SIGNED: begin
                is_trap = 1'b1;
                cmp_signed = 1'b1;
                cmp_cond = CMP_LT;
            end
            OP_TRAP_LT_REG_UNSIGNED: begin
                is_trap = 1'b1;
                cmp_cond = CMP_LT;
            end
            OP_TRAP_EQ_REG: begin
                is_trap = 1'b1;
                cmp_cond = CMP_EQ;
            end
            OP_TRAP_NE_REG: begin
                is_trap = 1'b1;
                cmp_cond = CMP_NE;
            end
            OP_TRAP_GE_IMM_SIGNED: begin
                is_trap = 1'b1;
                use_imm = 1'b1;
                cmp_signed = 1'b1;
                cmp_cond = CMP_GE;
            end
            OP_TRAP_GE_IMM_UNSIGNED: begin
                is_trap = 1'b1;
                use_imm = 1'b1;
                cmp_cond = CMP_GE;
            end
            OP_TRAP_LT_IMM_SIGNED: begin
                is_trap = 1'b1;
                use_imm = 1'b1;
                cmp_signed = 1'b1;
                cmp_cond = CMP_LT;
            end
            OP_TRAP_LT_IMM_UNSIGNED: begin
                is_trap = 1'b1;
                use_imm = 1'b1;
                cmp_cond = CMP_LT;
            end
            OP_TRAP_EQ_IMM: begin
                is_trap = 1'b1;
                use_imm = 1'b1;
                cmp_signed = 1'b1;
                cmp_cond = CMP_EQ;
            end
            OP_TRAP_NE_IMM: begin
                is_trap = 1'b1;
                use_imm = 1'b1;
                cmp_signed = 1'b1;
                cmp_cond = CMP_NE;
            end
            default: begin
                is_mem = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Operand preparation
    // ************************************************************
    // In 32-bit mode only the low word is architectural, so both operands are
    // widened from bit 31 and the comparison width stays fixed.
    logic [XLEN-1:0] lhs;
    logic [XLEN-1:0] rhs_reg;
    logic [XLEN-1:0] imm_ext;
    logic [XLEN-1:0] rhs;
    logic imm_sext;

    always_comb begin
        if (ex_req.mode32) begin
            lhs = {{HALF{ex_req.first_source_register[HALF-1]}}, ex_req.first_source_register[HALF-1:0]};
            rhs_reg = {{HALF{ex_req.second_source_register[HALF-1]}}, ex_req.second_source_register[HALF-1:0]};
        end else begin
            lhs = ex_req.first_source_register;
            rhs_reg = ex_req.second_source_register;
        end
    end

    // Unsigned immediates extend by the parameter; signed ones always by sign.
    assign imm_sext = cmp_signed || UIMM_SIGN_EXT; // RULE10 RULE11

    always_comb begin
        if (imm_sext) begin
            imm_ext = {{(XLEN-IMM_W){ex_req.imm[IMM_W-1]}}, ex_req.imm}; // RULE10
        end else begin
            imm_ext = {{(XLEN-IMM_W){1'b0}}, ex_req.imm}; // RULE11
        end
    end

    assign rhs = use_imm ? imm_ext : rhs_reg;

    // ************************************************************
    // Condition evaluation
    // ************************************************************
    logic cmp_hit;
    logic mem_wait;

    tse_trap_cmp u_cmp (
        .lhs(lhs),
        .rhs(rhs),
        .is_signed(cmp_signed),
        .cond(cmp_cond),
        .hit(cmp_hit)
    );

    // ************************************************************
    // Memory ordering
    // ************************************************************
    tse_state_t state_ff;
    logic mem_hold;
    logic mem_full;
    logic accept;
    logic exc_hit;
    tse_cause_t hit_cause;

    // A full in-flight count also holds loads and stores. The counter saturates,
    // so one more would go uncounted and a later synchronise could release
    // before that access has finished.
    assign mem_full = mem_inflight == INFL_MAX; // RULE1
    assign mem_hold = is_mem && (mem_wait || mem_full); // RULE1
    assign accept = ex_req.valid && (state_ff == ST_RUN) && !mem_hold;

    tse_sync_gate u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .mem_issue(accept && is_mem),
        .mem_done(mem_done),
        .sync_issue(accept && is_sync),
        .mem_wait(mem_wait),
        .inflight(mem_inflight)
    );

    logic trap_hit;

    assign trap_hit = is_trap && cmp_hit; // RULE6 RULE7 RULE8 RULE9 RULE12 RULE13 RULE14 RULE15

    always_comb begin
        if (is_syscall) begin
            hit_cause = CAUSE_SYSCALL; // RULE2
        end else if (is_break) begin
            hit_cause = CAUSE_BREAK; // RULE3
        end else if (trap_hit) begin
            hit_cause = CAUSE_TRAP;
        end else begin
            hit_cause = CAUSE_NONE;
        end
    end

    assign exc_hit = accept && (hit_cause != CAUSE_NONE); // RULE2 RULE3

    // ************************************************************
    // Pipeline handshake
    // ************************************************************
    // The flush kills the instruction in execute and everything younger in the
    // same cycle, so nothing after the excepting one reaches write-back.
    assign ex_flush = exc_hit; // RULE17
    assign ex_done = accept && !exc_hit; // RULE16
    // While an exception waits for entry the slot is held; the pipeline has
    // already been flushed, so anything presented here is wrong-path.
    assign ex_stall = ex_req.valid && (mem_hold || (state_ff == ST_RAISE)); // RULE17

    // ************************************************************
    // Exception hand-off to the entry logic
    // ************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_RUN;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (exc_hit) begin
                        state_ff <= ST_RAISE;
                    end
                end
                ST_RAISE: begin
                    if (exc_ack) begin
                        state_ff <= ST_RUN;
                    end
                end
                default: begin
                    state_ff <= ST_RUN;
                end
            endcase
        end
    end

    // Each field of the hand-off is its own register, read out as one word.
    // A new exception wins over a stray acknowledge seen in the same cycle.
    logic exc_valid_ff;
    tse_cause_t exc_cause_ff;
    logic [XLEN-1:0] exc_epc_ff;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            exc_valid_ff <= EXC_RST.valid;
        end else if (exc_hit) begin
            exc_valid_ff <= 1'b1; // RULE17
        end else if (exc_ack) begin
            exc_valid_ff <= EXC_RST.valid;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            exc_cause_ff <= EXC_RST.cause;
        end else if (exc_hit) begin
            exc_cause_ff <= hit_cause;
        end else if (exc_ack) begin
            exc_cause_ff <= EXC_RST.cause;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            exc_epc_ff <= EXC_RST.epc;
        end else if (exc_hit) begin
            exc_epc_ff <= ex_req.pc;
        end else if (exc_ack) begin
            exc_epc_ff <= EXC_RST.epc;
        end
    end

    assign exc_out = '{valid: exc_valid_ff, cause: exc_cause_ff, epc: exc_epc_ff};

endmodule

// file: testbench/tse_exc_unit_monitor.sv
// Concurrent checks on the ports of the special-instruction unit.
`timescale 1ns/1ns
module tse_exc_unit_monitor
    import tse_pkg::*;
#(
    parameter bit UIMM_SIGN_EXT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire tse_ex_req_t ex_req,
    input wire logic mem_done,
    input wire logic exc_ack,
    input wire logic ex_stall,
    input wire logic ex_done,
    input wire logic ex_flush,
    input wire tse_exc_t exc_out,
    input wire logic [INFL_W-1:0] mem_inflight
);
    logic go;
    logic [XLEN-1:0] a;
    logic [XLEN-1:0] b;
    logic [XLEN-1:0] se;
    assign go = ex_req.valid && !ex_stall && !ex_req.mode32;
    assign a = ex_req.first_source_register;
    assign b = ex_req.second_source_register;
    assign se = {{48{ex_req.imm[15]}}, ex_req.imm};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ************************************************************
    // Properties
    // ************************************************************
    property p_syscall;
        go && ex_req.op == OP_SYSCALL |-> ex_flush ##1
            exc_out.valid && exc_out.cause == CAUSE_SYSCALL && exc_out.epc == $past(ex_req.pc);
    endproperty
    a_syscall: assert property (p_syscall) else $error("syscall not raised");
    property p_break;
        go && ex_req.op == OP_BREAK |-> ex_flush ##1 exc_out.valid && exc_out.cause == CAUSE_BREAK;
    endproperty
    a_break: assert property (p_break) else $error("breakpoint not raised");
    property p_excl;
        !(ex_flush && ex_done);
    endproperty
    a_excl: assert property (p_excl) else $error("flush and done together");
    property p_hold;
        exc_out.valid && ex_req.valid |-> ex_stall && !ex_done && !ex_flush;
    endproperty
    a_hold: assert property (p_hold) else $error("slot moved while exception pending");
    property p_eq_reg;
        go && ex_req.op == OP_TRAP_EQ_REG |-> ex_flush == (a == b);
    endproperty
    a_eq_reg: assert property (p_eq_reg) else $error("equal register trap wrong");
    property p_ne_reg;
        go && ex_req.op == OP_TRAP_NE_REG |-> ex_flush == (a != b);
    endproperty
    a_ne_reg: assert property (p_ne_reg) else $error("unequal register trap wrong");
    property p_ge_s;
        go && ex_req.op == OP_TRAP_GE_REG_SIGNED |-> ex_flush == ($signed(a) >= $signed(b));
    endproperty
    a_ge_s: assert property (p_ge_s) else $error("signed ge trap wrong");
    property p_lt_u;
        go && ex_req.op == OP_TRAP_LT_REG_UNSIGNED |-> ex_flush == (a < b);
    endproperty
    a_lt_u: assert property (p_lt_u) else $error("unsigned lt trap wrong");
    property p_ge_imm;
        go && ex_req.op == OP_TRAP_GE_IMM_SIGNED |-> ex_flush == ($signed(a) >= $signed(se));
    endproperty
    a_ge_imm: assert property (p_ge_imm) else $error("signed ge immediate trap wrong");
    property p_quiet;
        ex_done |=> !exc_out.valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("completed op raised exception");
    property p_sync_hold;
        ex_done && ex_req.op == OP_SYNC && mem_inflight != INFL_RST && !mem_done |=>
            !(ex_done && (ex_req.op == OP_LOAD || ex_req.op == OP_STORE));
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("load or store passed a pending synchronise");
    property p_ack;
        exc_out.valid && exc_ack |=> !exc_out.valid;
    endproperty
    a_ack: assert property (p_ack) else $error("exception not released after acknowledge");
    c_sys: cover property (go && ex_req.op == OP_SYSCALL);
    c_trap: cover property (ex_flush ##1 exc_ack);
    c_sync: cover property (ex_stall && !exc_out.valid);
endmodule
bind tse_exc_unit tse_exc_unit_monitor #(.UIMM_SIGN_EXT(UIMM_SIGN_EXT)) mon_i (.ref_clk(ref_clk),
    .reset_n(reset_n), .ex_req(ex_req), .mem_done(mem_done), .exc_ack(exc_ack), .ex_stall(ex_stall),
    .ex_done(ex_done), .ex_flush(ex_flush), .exc_out(exc_out), .mem_inflight(mem_inflight));

// file: testbench/tse_pipe_model.sv
// Memory completion and exception entry model for the far side.
`timescale 1ns/1ns
module tse_pipe_model
    import tse_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic exc_valid,
    input wire logic [INFL_W-1:0] mem_inflight,
    input wire logic hold_mem,
    input wire logic slow,
    output logic exc_ack,
    output logic mem_done
);
    logic [2:0] wait_ff;
    // A slow entry makes the unit hold its exception for several cycles.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_ff <= 3'h0;
        end else if (!exc_valid) begin
            wait_ff <= 3'h0;
        end else if (wait_ff != 3'h7) begin
            wait_ff <= wait_ff + 3'h1;
        end
    end
    assign exc_ack = exc_valid && (wait_ff >= (slow ? 3'h4 : 3'h0));
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_done <= 1'b0;
        end else begin
            mem_done <= !hold_mem && (mem_inflight != INFL_RST) && !mem_done;
        end
    end
endmodule

// file: testbench/tb_tse_exc_unit.sv
// Self-checking bench for the special-instruction unit.
`timescale 1ns/1ns
module tb_tse_exc_unit
    import tse_pkg::*;
;
    logic ref_clk;
    logic reset_n;
    tse_ex_req_t ex_req;
    logic mem_done;
    logic exc_ack;
    logic ex_stall;
    logic ex_done;
    logic ex_flush;
    tse_exc_t exc_out;
    logic [INFL_W-1:0] mem_inflight;
    logic hold_mem;
    logic slow;
    logic [XLEN-1:0] pc;
    logic m32;
    int mismatches;
    int n_tests;
    logic [XLEN-1:0] va [3] = '{64'hffff_ffff_ffff_ffff, 64'h5, 64'hffff};
    logic [XLEN-1:0] vb [3] = '{64'h1, 64'h5, 64'hffff_ffff_ffff_ffff};
    logic [IMM_W-1:0] vi [3] = '{16'hffff, 16'h0006, 16'hffff};

    tse_exc_unit tse_exc_unit_i (.ref_clk(ref_clk), .reset_n(reset_n), .ex_req(ex_req), .mem_done(mem_done),
        .exc_ack(exc_ack), .ex_stall(ex_stall), .ex_done(ex_done), .ex_flush(ex_flush), .exc_out(exc_out),
        .mem_inflight(mem_inflight));
    tse_pipe_model tse_pipe_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .exc_valid(exc_out.valid),
        .mem_inflight(mem_inflight), .hold_mem(hold_mem), .slow(slow), .exc_ack(exc_ack), .mem_done(mem_done));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic tse_ex_req_t mk(input tse_op_t op);
        return '{valid: 1'b1, mode32: m32, op: op, pc: pc, first_source_register: 64'h0,
            second_source_register: 64'h0, imm: 16'h0};
    endfunction
    // Expected trap outcome, with the unsigned immediate zero-extended.
    function automatic logic exp_hit(input tse_op_t op, input logic [63:0] a, input logic [63:0] b,
        input logic [15:0] imm);
        logic [63:0] se;
        logic [63:0] ze;
        se = {{48{imm[15]}}, imm};
        ze = {48'h0, imm};
        case (op)
            OP_TRAP_GE_REG_SIGNED: return $signed(a) >= $signed(b);
            OP_TRAP_GE_REG_UNSIGNED: return a >= b;
            OP_TRAP_LT_REG_SIGNED: return $signed(a) < $signed(b);
            OP_TRAP_LT_REG_UNSIGNED: return a < b;
            OP_TRAP_EQ_REG: return a == b;
            OP_TRAP_NE_REG: return a != b;
            OP_TRAP_GE_IMM_SIGNED: return $signed(a) >= $signed(se);
            OP_TRAP_GE_IMM_UNSIGNED: return a >= ze;
            OP_TRAP_LT_IMM_SIGNED: return $signed(a) < $signed(se);
            OP_TRAP_LT_IMM_UNSIGNED: return a < ze;
            OP_TRAP_EQ_IMM: return a == se;
            OP_TRAP_NE_IMM: return a != se;
            default: return 1'b0;
        endcase
    endfunction
    task automatic run_op(input tse_op_t op, input logic [63:0] a, input logic [63:0] b,
        input logic [15:0] imm, input tse_cause_t c);
        int k;
        @(negedge ref_clk);
        ex_req = mk(op);
        ex_req.first_source_register = a;
        ex_req.second_source_register = b;
        ex_req.imm = imm;
        #1;
        check(ex_flush, c != CAUSE_NONE);
        check(ex_done, c == CAUSE_NONE);
        @(negedge ref_clk);
        ex_req.op = OP_NONE;
        #1;
        if (c == CAUSE_NONE) begin
            check({exc_out.valid, ex_done}, 2'b01);
        end else begin
            check(exc_out, {1'b1, c, pc});
            check({ex_stall, ex_done, ex_flush}, 3'b100);
            k = 0;
            while (exc_out.valid && k < 20) begin
                @(negedge ref_clk);
                k++;
            end
            if (k == 20) begin
                mismatches++;
                give_verdict();
            end
        end
        ex_req.valid = 1'b0;
        pc = pc + 64'h4;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_traps();
        tse_op_t op;
        tse_cause_t cs;
        for (int i = 6; i <= 17; i++) begin
            for (int s = 0; s < 3; s++) begin
                slow = s[0];
                op = tse_op_t'(i[4:0]);
                cs = exp_hit(op, va[s], vb[s], vi[s]) ? CAUSE_TRAP : CAUSE_NONE;
                run_op(op, va[s], vb[s], vi[s], cs);
            end
        end
    endtask
    // In 32-bit mode only the low words count, widened from bit 31.
    task automatic test_mode32();
        m32 = 1'b1;
        run_op(OP_TRAP_LT_REG_SIGNED, 64'h0000_0000_8000_0000, 64'h1, 16'h0, CAUSE_TRAP);
        run_op(OP_TRAP_EQ_REG, 64'hffff_ffff_0000_0005, 64'h5, 16'h0, CAUSE_TRAP);
        run_op(OP_TRAP_LT_IMM_UNSIGNED, 64'h1234_5678_0000_0004, 64'h0, 16'h0005, CAUSE_TRAP);
        m32 = 1'b0;
    endtask
    task automatic test_specials();
        run_op(OP_SYSCALL, 64'h0, 64'h0, 16'h0, CAUSE_SYSCALL);
        run_op(OP_BREAK, 64'h1, 64'h1, 16'h0, CAUSE_BREAK);
        run_op(OP_OTHER, 64'h1, 64'h1, 16'h0, CAUSE_NONE);
    endtask
    task automatic test_sync();
        int k;
        @(negedge ref_clk);
        hold_mem = 1'b1;
        ex_req = mk(OP_LOAD);
        #1;
        check(ex_done, 1'b1);
        @(negedge ref_clk);
        ex_req.op = OP_SYNC;
        #1;
        check(ex_done, 1'b1);
        repeat (3) begin
            @(negedge ref_clk);
            ex_req.op = OP_STORE;
            #1;
            check({ex_stall, ex_done, mem_inflight}, {2'b10, INFL_ONE});
        end
        @(negedge ref_clk);
        hold_mem = 1'b0;
        k = 0;
        while (!ex_done && k < 20) begin
            @(negedge ref_clk);
            #1;
            k++;
        end
        check(k < 20, 1'b1);
        if (k == 20) begin
            give_verdict();
        end
        @(negedge ref_clk);
        ex_req.op = OP_SYNC;
        #1;
        check(mem_inflight, INFL_ONE);
        k = 0;
        while (mem_inflight != INFL_RST && k < 20) begin
            @(negedge ref_clk);
            k++;
        end
        check(k < 20, 1'b1);
        if (k == 20) begin
            give_verdict();
        end
        ex_req.op = OP_STORE;
        #1;
        check({ex_stall, ex_done}, 2'b01);
        @(negedge ref_clk);
        ex_req.valid = 1'b0;
    endtask

    initial begin
        ex_req = '0;
        hold_mem = 1'b0;
        slow = 1'b0;
        pc = 64'h1000;
        m32 = 1'b0;
        mismatches = 0;
        n_tests = 0;
        reset_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        reset_n = 1'b1;
        check({exc_out, mem_inflight}, {EXC_RST, INFL_RST});
        test_specials();
        test_traps();
        test_mode32();
        test_sync();
        repeat (4) @(negedge ref_clk);
        give_verdict();
    end
endmodule
